/* File: rtl/sdr_ctrl.sv */
`timescale 1ns/10ps
module sdr_ctrl
  import sdr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic video_phase_clock_i,
  input wire logic cpu_req_i,
  input wire logic cpu_wr_n_i,
  input wire logic refresh_indication_i,
  input wire logic lower_bank_select_i,
  input wire logic upper_bank_select_i,
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  input wire logic [ADDR_W-1:0] video_addr_i,
  input wire logic cpu_data_i,
  input wire logic lower_dout_i,
  input wire logic upper_dout_i,
  input wire logic upper_bank_read_enable_n_i,
  output logic [HALF_W-1:0] ram_addr_o,
  output logic ras_n_o,
  output logic cas_lower_n_o,
  output logic cas_upper_n_o,
  output logic ram_wr_n_o,
  output logic ram_din_o,
  output logic cpu_rdata_o,
  output logic cpu_rdata_oe_o,
  output logic video_rdata_o,
  output logic busy_o
);

  typedef struct packed {
    sdr_state_e st;
    logic [ADDR_W-1:0] addr;
    logic is_video;
    logic is_refresh_indication;
    logic wr;
    logic lo_sel;
    logic hi_sel;
    logic [HALF_W-1:0] ram_addr;
    logic ras_n;
    logic cas_lo_n;
    logic cas_hi_n;
    logic wr_n;
    logic din;
    logic lo_latch;
    logic hi_latch;
    logic vid_latch;
  } sdr_s;

  logic rst_sync1_ff;
  logic rst_sync2_ff;
  sdr_s st_ff;
  sdr_s nxt_st;
  logic start;

  // Decoded request of the slot now offered
  logic take_refresh_indication;
  logic take_video;
  logic take_cpu;
  logic take_wr;
  logic take_lo;
  logic take_hi;
  logic [ADDR_W-1:0] take_addr;

  // Halves of the address held for this cycle
  logic [HALF_W-1:0] row_half;
  logic [HALF_W-1:0] col_half;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Refresh wins over video, video over the processor
  always_comb begin
    take_refresh_indication = 1'b0;
    take_video = 1'b0;
    take_cpu = 1'b0;
    if (refresh_indication_i) begin
      take_refresh_indication = 1'b1;
    end else if (video_phase_clock_i) begin
      take_video = 1'b1;
    end else if (cpu_req_i) begin
      take_cpu = 1'b1;
    end
  end

  // Refresh needs no counter here; the processor paces it
  assign start = take_refresh_indication | take_video | take_cpu;

  // Video slot picks the video address, else the processor
  always_comb begin
    if (take_video) begin
      take_addr = video_addr_i;
    end else begin
      take_addr = cpu_addr_i;
    end
  end

  // Refresh and video cycles never write
  assign take_wr = ~cpu_wr_n_i & take_cpu;
  assign take_lo = take_video | lower_bank_select_i;
  assign take_hi = ~take_video & upper_bank_select_i;

  assign row_half = st_ff.addr[ROW_LSB +: HALF_W];
  assign col_half = st_ff.addr[COL_LSB +: HALF_W];

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.st)

      // Request, address and bank inputs are taken on the edge that leaves idle
      SDR_IDLE: begin
        nxt_st.ras_n = 1'b1;
        nxt_st.cas_lo_n = 1'b1;
        nxt_st.cas_hi_n = 1'b1;
        nxt_st.wr_n = 1'b1;
        if (start) begin
          nxt_st.is_video = take_video;
          nxt_st.is_refresh_indication = take_refresh_indication;
          nxt_st.addr = take_addr;
          nxt_st.wr = take_wr;
          nxt_st.lo_sel = take_lo;
          nxt_st.hi_sel = take_hi;
          nxt_st.st = SDR_ROW;
        end else begin
          nxt_st.st = SDR_IDLE;
        end
      end

      // Row half settles a full cycle before the row strobe
      SDR_ROW: begin
        nxt_st.ram_addr = row_half;
        nxt_st.din = cpu_data_i;
        nxt_st.ras_n = 1'b1;
        nxt_st.cas_lo_n = 1'b1;
        nxt_st.cas_hi_n = 1'b1;
        nxt_st.wr_n = 1'b1;
        nxt_st.st = SDR_RAS;
      end

      // Row strobe falls on both banks; address still holds the row
      SDR_RAS: begin
        nxt_st.ram_addr = row_half;
        nxt_st.ras_n = 1'b0;
        nxt_st.cas_lo_n = 1'b1;
        nxt_st.cas_hi_n = 1'b1;
        nxt_st.wr_n = 1'b1;
        if (st_ff.is_refresh_indication) begin
          // Row only: no column and no transfer
          nxt_st.st = SDR_END;
        end else begin
          nxt_st.st = SDR_COL;
        end
      end

      // Column half only once the row strobe is down
      SDR_COL: begin
        nxt_st.ram_addr = col_half;
        nxt_st.ras_n = 1'b0;
        nxt_st.cas_lo_n = 1'b1;
        nxt_st.cas_hi_n = 1'b1;
        nxt_st.wr_n = ~st_ff.wr;
        nxt_st.st = SDR_CAS;
      end

      // Column strobe doubles as the bank select
      SDR_CAS: begin
        nxt_st.ram_addr = col_half;
        nxt_st.ras_n = 1'b0;
        nxt_st.cas_lo_n = ~st_ff.lo_sel;
        nxt_st.cas_hi_n = ~st_ff.hi_sel;
        nxt_st.wr_n = ~st_ff.wr;
        nxt_st.st = SDR_END;
      end

      // Chip drives its output while both strobes are still low
      SDR_END: begin
        if (!st_ff.is_refresh_indication && !st_ff.wr) begin
          if (st_ff.is_video) begin
            nxt_st.vid_latch = lower_dout_i;
          end else begin
            nxt_st.lo_latch = lower_dout_i;
            nxt_st.hi_latch = upper_dout_i;
          end
        end
        nxt_st.ras_n = 1'b1;
        nxt_st.cas_lo_n = 1'b1;
        nxt_st.cas_hi_n = 1'b1;
        nxt_st.wr_n = 1'b1;
        nxt_st.st = SDR_IDLE;
      end

      // Two codes are unused; fall back with strobes released
      default: begin
        nxt_st.ras_n = 1'b1;
        nxt_st.cas_lo_n = 1'b1;
        nxt_st.cas_hi_n = 1'b1;
        nxt_st.wr_n = 1'b1;
        nxt_st.st = SDR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      // Strobes idle high so no chip sees a stray cycle
      st_ff <= '{
        st: SDR_IDLE,
        ras_n: 1'b1,
        cas_lo_n: 1'b1,
        cas_hi_n: 1'b1,
        wr_n: 1'b1,
        default: '0
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign ram_addr_o = st_ff.ram_addr;
  assign ras_n_o = st_ff.ras_n;
  assign cas_lower_n_o = st_ff.cas_lo_n;
  assign cas_upper_n_o = st_ff.cas_hi_n;
  assign ram_wr_n_o = st_ff.wr_n;
  assign ram_din_o = st_ff.din;

  // Upper latch only owns the bus under its enable
  always_comb begin
    if (upper_bank_read_enable_n_i) begin
      cpu_rdata_o = st_ff.lo_latch;
    end else begin
      cpu_rdata_o = st_ff.hi_latch;
    end
  end

  assign cpu_rdata_oe_o = ~upper_bank_read_enable_n_i;
  assign video_rdata_o = st_ff.vid_latch;
  assign busy_o = (st_ff.st != SDR_IDLE);

endmodule

/* File: rtl/sdr_pkg.sv */
package sdr_pkg;
  localparam int ADDR_W = 14;
  localparam int HALF_W = 7;
  localparam int ROW_LSB = 0;
  localparam int COL_LSB = 7;
  localparam int REFRESH_MS = 2;
  localparam int CLK_HZ = 50000000;
  localparam int REFRESH_CYC = REFRESH_MS * (CLK_HZ / 1000);
  typedef enum logic [2:0] {
    SDR_IDLE = 3'b000,
    SDR_ROW = 3'b001,
    SDR_RAS = 3'b011,
    SDR_COL = 3'b010,
    SDR_CAS = 3'b110,
    SDR_END = 3'b111
  } sdr_state_e;
endpackage

/* File: verif/sdr_ram_model.sv */
`timescale 1ns/10ps
module sdr_ram_model
  import sdr_pkg::*;
(
  input wire logic ras_n_i, cas_n_i, wr_n_i, din_i,
  input wire logic [HALF_W-1:0] addr_i,
  output logic dout_o
);
  logic mem [0:16383];
  logic [HALF_W-1:0] row;
  logic q;
  always @(negedge ras_n_i) row = addr_i;
  always @(negedge cas_n_i) if (!ras_n_i) begin
    if (!wr_n_i) mem[{addr_i, row}] = din_i;
    q = mem[{addr_i, row}];
  end
  // Released line shows the inverse so stale bits never pass
  assign dout_o = cas_n_i ? ~q : q;
endmodule

/* File: verif/sdr_ctrl_asserts.sv */
`timescale 1ns/10ps
module sdr_ctrl_asserts
  import sdr_pkg::*;
(
  input wire logic sys_clk_i, arst_n_i, video_phase_clock_i, cpu_req_i,
  input wire logic refresh_indication_i, lower_bank_select_i, upper_bank_select_i,
  input wire logic upper_bank_read_enable_n_i, ras_n_o, cas_lower_n_o, cas_upper_n_o,
  input wire logic ram_wr_n_o, cpu_rdata_oe_o, busy_o,
  input wire logic [HALF_W-1:0] ram_addr_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  wire rfs = !busy_o && refresh_indication_i;
  wire vid = !busy_o && video_phase_clock_i && !refresh_indication_i;
  wire cpu = !busy_o && cpu_req_i && !video_phase_clock_i && !refresh_indication_i;
  a_row_hold: assert property ($fell(ras_n_o) |-> $stable(ram_addr_o))
    else $error("row moved");
  a_cas_in_ras: assert property (!(cas_lower_n_o && cas_upper_n_o) |-> $past(!ras_n_o))
    else $error("cas early");
  a_refresh_ras: assert property (rfs |-> ##3 !ras_n_o)
    else $error("no refresh ras");
  a_refresh_nocas: assert property (rfs |=> (cas_lower_n_o && cas_upper_n_o && ram_wr_n_o)[*5])
    else $error("refresh cas");
  a_video_lower: assert property (vid |-> ##5 (!cas_lower_n_o && cas_upper_n_o && ram_wr_n_o))
    else $error("video cas");
  a_cpu_bank: assert property (cpu |-> ##5 (cas_lower_n_o != $past(lower_bank_select_i, 5) &&
    cas_upper_n_o != $past(upper_bank_select_i, 5)))
    else $error("bank cas");
  a_ras_every: assert property (cpu || vid |-> ##3 !ras_n_o [*3] ##1 ras_n_o)
    else $error("ras shape");
  a_end_high: assert property ($rose(ras_n_o) |-> cas_lower_n_o && cas_upper_n_o)
    else $error("cas stuck");
  a_oe_enable: assert property (cpu_rdata_oe_o == !upper_bank_read_enable_n_i)
    else $error("oe");
endmodule
bind sdr_ctrl sdr_ctrl_asserts sdr_ctrl_asserts_i(.*);

/* File: verif/test_sdr_ctrl.sv */
`timescale 1ns/10ps
module test_sdr_ctrl;
  import sdr_pkg::*;
  logic clk = 0, rst_n = 0, vp = 0, rq = 0, wn = 1, rf = 0, ls = 0, us = 0, cd = 0, ren = 1;
  logic [13:0] ca = 0, va = 0;
  logic [6:0] ra;
  logic rn, cl, cu, rw, rd, cr, vr, bz, lo, hi;
  logic [31:0] s = 32'h6FE1;
  int err_count = 0, tests_run = 0, cyc = 0;
  logic sl [0:16383];
  logic sh [0:16383];
  initial forever #10 clk = ~clk;
  sdr_ctrl sdr_ctrl_i(.sys_clk_i(clk), .arst_n_i(rst_n), .video_phase_clock_i(vp),
    .cpu_req_i(rq), .cpu_wr_n_i(wn), .refresh_indication_i(rf), .lower_bank_select_i(ls),
    .upper_bank_select_i(us), .cpu_addr_i(ca), .video_addr_i(va), .cpu_data_i(cd),
    .lower_dout_i(lo), .upper_dout_i(hi), .upper_bank_read_enable_n_i(ren), .ram_addr_o(ra),
    .ras_n_o(rn), .cas_lower_n_o(cl), .cas_upper_n_o(cu), .ram_wr_n_o(rw), .ram_din_o(rd),
    .cpu_rdata_o(cr), .cpu_rdata_oe_o(), .video_rdata_o(vr), .busy_o(bz));
  sdr_ram_model sdr_ram_model_i[1:0](.ras_n_i(rn), .cas_n_i({cu, cl}), .wr_n_i(rw),
    .din_i(rd), .addr_i(ra), .dout_o({hi, lo}));
  function logic [31:0] lf(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task cmp(input logic g, e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("errors %0d tests %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Video reads take the other bus a wrong address, so a bad mux shows
  task op(input logic v, r, w, u, d, input logic [13:0] x);
    int n;
    @(posedge clk);
    {vp, rf, rq, wn, us, ls, cd, ren} <= {v, r, !v && !r, w, u, !u, d, !u};
    ca <= v ? ~x : x;
    va <= v ? x : ~x;
    repeat (2) @(posedge clk);
    {vp, rf, rq} <= 3'h0;
    for (n = 0; n < 9 && bz !== 1'b0; n++) @(posedge clk) #1;
    if (!v && !r && !w && u) sh[x] = d;
    if (!v && !r && !w && !u) sl[x] = d;
    if (v || (!r && w)) cmp(v ? vr : cr, (u && !v) ? sh[x] : sl[x]);
  endtask
  initial begin
    logic [13:0] x;
    repeat (20) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 60; i++) begin
      s = lf(s);
      x = (i < 2) ? (i ? 14'h3FFF : 14'h0000) : s[13:0];
      op(0, 0, 0, 0, s[17], x);
      op(0, 0, 0, 1, s[18], x);
      op(0, 1, 0, s[16], ~s[17], x);
      op(0, 0, 1, s[16], 0, x);
      op(1, 0, s[19], s[16], 0, x);
    end
    close_out;
  end
  always @(posedge clk) if (++cyc > 5000) begin
    err_count++;
    close_out;
  end
endmodule
